// [src/dpsc_host.sv]
`timescale 1ns/10ps
// What this block does
// - Read: R/W high, chip select and output enable low, address set before.
// - Address changes only while chip select and R/W are high.
// - Write data driven only after device outputs turned off.
// - Write pulse stretched to hi-z plus setup when output enable low.
// - Chip select low at least its minimum before write end.
// - Address held valid at least its minimum before write end.
// - Write data valid at least setup time before write end.
// - Write data held past the end of write.
// - Recovery wait after write before next cycle.
module dpsc_host #(
  parameter int ADDR_W = dpsc_pkg::ADDR_W,
  parameter int DATA_W = dpsc_pkg::DATA_W
) (
  input  wire logic              mclk,
  input  wire logic              resetn,
  input  wire logic              req_valid,
  input  wire logic              req_write,
  input  wire logic [ADDR_W-1:0] req_addr,
  input  wire logic [DATA_W-1:0] req_wdata,
  output logic                   req_ready,
  output logic                   rsp_valid,
  output logic [DATA_W-1:0]      rsp_rdata,
  output logic                   rsp_busy,
  output logic [ADDR_W-1:0]      sram_addr,
  output logic                   sram_cs_n,
  output logic                   sram_rw,
  output logic                   sram_oe_n,
  input  wire logic [DATA_W-1:0] sram_data_i,
  output logic [DATA_W-1:0]      sram_data_o,
  output logic                   sram_data_oe,
  input  wire logic              sram_busy_n
);
  localparam int CW = dpsc_pkg::CNT_W;
  dpsc_pkg::dpsc_state_type st_q, st_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic [DATA_W-1:0] wd_q, wd_d, rd_q, rd_d;
  logic              cs_n_q, cs_n_d, rw_q, rw_d, oe_n_q, oe_n_d, doe_q, doe_d;
  logic              rdy_q, rdy_d, rv_q, rv_d, rb_q, rb_d, bwait_q, bwait_d;
  logic [DATA_W-1:0] din_s1_q, din_s2_q;
  logic              busy_s1_q, busy_s2_q, busy_seen_q, busy_seen_d;
  logic              t_load, t_busy, t_done;
  logic [CW-1:0]     t_count;

  // Cycle count cut to the timer width on purpose
  function automatic logic [CW-1:0] cyc(input int n);
    return CW'(n);
  endfunction : cyc

  // Two-stage synchronisers for pins from the device
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      din_s1_q  <= '0;
      din_s2_q  <= '0;
      busy_s1_q <= 1'b1;
      busy_s2_q <= 1'b1;
    end else begin
      din_s1_q  <= sram_data_i;
      din_s2_q  <= din_s1_q;
      busy_s1_q <= sram_busy_n;
      busy_s2_q <= busy_s1_q;
    end
  end

  dpsc_timer #(.W(CW)) u_timer (
    .mclk   (mclk),
    .resetn (resetn),
    .load   (t_load),
    .count  (t_count),
    .busy   (t_busy),
    .done   (t_done)
  );

  // Cycle sequencer next state
  always_comb begin
    st_d = st_q;
    addr_d = addr_q;
    wd_d = wd_q;
    rd_d = rd_q;
    cs_n_d = cs_n_q;
    rw_d = rw_q;
    oe_n_d = oe_n_q;
    doe_d = doe_q;
    rdy_d = rdy_q;
    rv_d = 1'b0;
    rb_d = rb_q;
    bwait_d = bwait_q;
    busy_seen_d = busy_seen_q;
    t_load = 1'b0;
    t_count = '0;
    case (st_q)
      dpsc_pkg::DPSC_IDLE: begin
        if (req_valid && rdy_q && !t_busy) begin
          rdy_d = 1'b0;
          addr_d = req_addr;                           // set while deselected
          wd_d = req_wdata;
          busy_seen_d = 1'b0;
          bwait_d = 1'b0;
          if (req_write) begin
            cs_n_d = 1'b0;                             // cs and R/W fall together
            rw_d = 1'b0;
            oe_n_d = 1'b1;                             // Keep device outputs off during write
            t_load = 1'b1;
            t_count = cyc(dpsc_pkg::HIZ_CYC);
            st_d = dpsc_pkg::DPSC_WHIZ;
          end else begin
            st_d = dpsc_pkg::DPSC_RSET;
          end
        end
      end
      dpsc_pkg::DPSC_RSET: begin
        cs_n_d = 1'b0;                                 // address already stable
        oe_n_d = 1'b0;
        rw_d = 1'b1;
        t_load = 1'b1;
        t_count = cyc(dpsc_pkg::RD_WAIT_CYC + 2);     // plus sync latency
        st_d = dpsc_pkg::DPSC_RWAIT;
      end
      dpsc_pkg::DPSC_RWAIT: begin
        if (!busy_s2_q) begin
          busy_seen_d = 1'b1;
        end
        if (t_done) begin
          if ((busy_seen_q || !busy_s2_q) && !bwait_q) begin
            bwait_d = 1'b1;                            // wait busy-release delay too
            t_load = 1'b1;
            t_count = cyc(dpsc_pkg::BUSY_WAIT_CYC + 2);
          end else begin
            rd_d = din_s2_q;                           // address still held
            rb_d = busy_seen_q;
            rv_d = 1'b1;
            cs_n_d = 1'b1;                             // deselect ends read
            oe_n_d = 1'b1;
            t_load = 1'b1;
            t_count = cyc(dpsc_pkg::STANDBY_CYC);
            rdy_d = 1'b1;
            st_d = dpsc_pkg::DPSC_IDLE;
          end
        end
      end
      dpsc_pkg::DPSC_WHIZ: begin
        if (t_done) begin
          doe_d = 1'b1;                                // device outputs now off
          t_load = 1'b1;
          t_count = cyc(dpsc_pkg::WR_PULSE_CYC);
          st_d = dpsc_pkg::DPSC_WPULS;
        end
      end
      dpsc_pkg::DPSC_WPULS: begin
        if (!busy_s2_q) begin
          busy_seen_d = 1'b1;
        end
        if (t_done) begin
          rw_d = 1'b1;                                 // R/W rises first, ends write
          t_load = 1'b1;
          t_count = cyc(dpsc_pkg::RECOV_CYC);          // data still driven
          st_d = dpsc_pkg::DPSC_RECOV;
        end
      end
      dpsc_pkg::DPSC_RECOV: begin
        if (t_done) begin
          doe_d = 1'b0;
          cs_n_d = 1'b1;
          rb_d = busy_seen_q;                          // Write may have been refused
          rv_d = 1'b1;
          t_load = 1'b1;
          t_count = cyc(dpsc_pkg::STANDBY_CYC);
          rdy_d = 1'b1;
          st_d = dpsc_pkg::DPSC_IDLE;
        end
      end
      default: begin
        st_d = dpsc_pkg::DPSC_IDLE;
        cs_n_d = 1'b1;
        rw_d = 1'b1;
        oe_n_d = 1'b1;
        doe_d = 1'b0;
        rdy_d = 1'b1;
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      st_q <= dpsc_pkg::DPSC_IDLE;
      addr_q <= '0;
      wd_q <= '0;
      rd_q <= '0;
      cs_n_q <= 1'b1;
      rw_q <= 1'b1;
      oe_n_q <= 1'b1;
      doe_q <= 1'b0;
      rdy_q <= 1'b1;
      rv_q <= 1'b0;
      rb_q <= 1'b0;
      bwait_q <= 1'b0;
      busy_seen_q <= 1'b0;
    end else begin
      st_q <= st_d;
      addr_q <= addr_d;
      wd_q <= wd_d;
      rd_q <= rd_d;
      cs_n_q <= cs_n_d;
      rw_q <= rw_d;
      oe_n_q <= oe_n_d;
      doe_q <= doe_d;
      rdy_q <= rdy_d;
      rv_q <= rv_d;
      rb_q <= rb_d;
      bwait_q <= bwait_d;
      busy_seen_q <= busy_seen_d;
    end
  end

  // Every output straight from its register
  assign req_ready = rdy_q;
  assign rsp_valid = rv_q;
  assign rsp_rdata = rd_q;
  assign rsp_busy = rb_q;
  assign sram_addr = addr_q;
  assign sram_cs_n = cs_n_q;
  assign sram_rw = rw_q;
  assign sram_oe_n = oe_n_q;
  assign sram_data_o = wd_q;
  assign sram_data_oe = doe_q;
endmodule : dpsc_host

// [src/dpsc_pkg.sv]
package dpsc_pkg;
  // Pin bus widths
  localparam int ADDR_W = 10;
  localparam int DATA_W = 8;
  // Clock period in ns
  localparam int CLK_NS = 40;
  // Speed grade timing figures in ns (slowest grade used as default)
  localparam int T_ACCESS_NS = 55;   // Address and chip select access
  localparam int T_OE_ACC_NS = 25;   // Output enable access
  localparam int T_BUSY_DATA_NS = 45; // Busy release to valid data
  localparam int T_OUT_HOLD_NS = 3;  // Old data kept after address change
  localparam int T_WRITE_PULSE_NS = 40;
  localparam int T_CS_TO_END_NS = 40;
  localparam int T_ADDR_TO_END_NS = 40;
  localparam int T_DATA_SETUP_NS = 20;
  localparam int T_WE_TO_HIZ_NS = 30;
  localparam int T_WRITE_DATA_HOLD_NS = 0;
  localparam int T_RECOVERY_NS = 0;
  localparam int T_STANDBY_NS = 50;
  // Ceiling to cycles, never under one cycle
  function automatic int ceil_cyc(input int ns);
    int c;
    c = (ns + CLK_NS - 1) / CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction : ceil_cyc
  // Read wait: last of address, chip select and output enable delays
  localparam int RD_WAIT_CYC = ceil_cyc((T_ACCESS_NS > T_OE_ACC_NS) ? T_ACCESS_NS : T_OE_ACC_NS);
  localparam int BUSY_WAIT_CYC = ceil_cyc(T_BUSY_DATA_NS);
  // Write pulse: larger of pulse minimum, cs/address to end, or hi-z plus setup
  localparam int WP_NS_A = (T_WRITE_PULSE_NS > T_CS_TO_END_NS) ? T_WRITE_PULSE_NS : T_CS_TO_END_NS;
  localparam int WP_NS_B = (WP_NS_A > T_ADDR_TO_END_NS) ? WP_NS_A : T_ADDR_TO_END_NS;
  localparam int WP_OE_NS = T_WE_TO_HIZ_NS + T_DATA_SETUP_NS;
  localparam int WR_PULSE_CYC = ceil_cyc((WP_NS_B > WP_OE_NS) ? WP_NS_B : WP_OE_NS);
  localparam int HIZ_CYC = ceil_cyc(T_WE_TO_HIZ_NS);
  localparam int RECOV_CYC = ceil_cyc(T_RECOVERY_NS + T_WRITE_DATA_HOLD_NS);
  localparam int STANDBY_CYC = ceil_cyc(T_STANDBY_NS);
  localparam int CNT_W = 4;
  typedef enum logic [5:0] {
    DPSC_IDLE  = 6'h01,
    DPSC_RSET  = 6'h02,
    DPSC_RWAIT = 6'h04,
    DPSC_WHIZ  = 6'h08,
    DPSC_WPULS = 6'h10,
    DPSC_RECOV = 6'h20
  } dpsc_state_type;
endpackage : dpsc_pkg

// [src/dpsc_timer.sv]
`timescale 1ns/10ps
// Down counter: loads a count, pulses done when it reaches one
module dpsc_timer #(
  parameter int W = 4
) (
  input  wire logic         mclk,
  input  wire logic         resetn,
  input  wire logic         load,
  input  wire logic [W-1:0] count,
  output logic              busy,
  output logic              done
);
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic         run_q;
  logic         run_d;
  // Next count and run flag
  always_comb begin
    cnt_d = cnt_q;
    run_d = run_q;
    if (load) begin
      cnt_d = count;
      run_d = 1'b1;
    end else if (run_q) begin
      if (cnt_q <= {{(W-1){1'b0}}, 1'b1}) begin
        run_d = 1'b0;
        cnt_d = '0;
      end else begin
        cnt_d = cnt_q - {{(W-1){1'b0}}, 1'b1};
      end
    end
  end
  // Register stage
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      cnt_q <= '0;
      run_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      run_q <= run_d;
    end
  end
  assign busy = run_q;
  assign done = run_q && (cnt_q <= {{(W-1){1'b0}}, 1'b1});
endmodule : dpsc_timer

// [tb/dpsc_host_chk.sv]
`timescale 1ns/10ps
// Pin ordering and pulse widths driven by the host
module dpsc_host_chk #(
  parameter int ADDR_W = 10,
  parameter int DATA_W = 8
) (
  input wire logic              mclk,
  input wire logic              resetn,
  input wire logic              req_valid,
  input wire logic              req_write,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [DATA_W-1:0] req_wdata,
  input wire logic              req_ready,
  input wire logic              rsp_valid,
  input wire logic [DATA_W-1:0] rsp_rdata,
  input wire logic              rsp_busy,
  input wire logic [ADDR_W-1:0] sram_addr,
  input wire logic              sram_cs_n,
  input wire logic              sram_rw,
  input wire logic              sram_oe_n,
  input wire logic [DATA_W-1:0] sram_data_i,
  input wire logic [DATA_W-1:0] sram_data_o,
  input wire logic              sram_data_oe,
  input wire logic              sram_busy_n
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  property p_rd_ctl; !sram_oe_n |-> sram_rw && !sram_cs_n && !sram_data_oe; endproperty
  a_rd_ctl: assert property (p_rd_ctl) else $error("output enable outside a read");
  property p_addr; !$stable(sram_addr) |-> $past(sram_cs_n); endproperty
  a_addr: assert property (p_addr) else $error("address moved while selected");
  property p_wstart; $fell(sram_rw) |-> $fell(sram_cs_n) && sram_oe_n; endproperty
  a_wstart: assert property (p_wstart) else $error("write start not with select");
  property p_hiz; $fell(sram_rw) |-> !sram_data_oe ##[1:4] sram_data_oe; endproperty
  a_hiz: assert property (p_hiz) else $error("data driven too early or never");
  property p_pulse; $fell(sram_rw) |-> !sram_rw [*2]; endproperty
  a_pulse: assert property (p_pulse) else $error("write pulse too short");
  property p_cs_end; $rose(sram_rw) |-> !$past(sram_cs_n, 2) && !$past(sram_cs_n); endproperty
  a_cs_end: assert property (p_cs_end) else $error("select too short before write end");
  property p_setup; $rose(sram_rw) |-> $past(sram_data_oe) && $stable(sram_data_o); endproperty
  a_setup: assert property (p_setup) else $error("write data setup short");
  property p_hold; $rose(sram_rw) |-> sram_data_oe && !sram_cs_n; endproperty
  a_hold: assert property (p_hold) else $error("write data not held");
  property p_recov; $rose(sram_rw) |-> ##[1:3] (sram_cs_n && !sram_data_oe && rsp_valid); endproperty
  a_recov: assert property (p_recov) else $error("write not closed in time");
  property p_rd_wait; $fell(sram_oe_n) |-> !sram_oe_n [*3]; endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read sampled too early");
  property p_gap; $rose(sram_cs_n) |-> sram_cs_n [*2]; endproperty
  a_gap: assert property (p_gap) else $error("standby gap too short");
  c_wr: cover property ($rose(sram_rw));
  c_rd: cover property (rsp_valid && !$past(sram_oe_n));
  c_busy: cover property (rsp_valid && rsp_busy);
endmodule : dpsc_host_chk
bind dpsc_host dpsc_host_chk #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_chk (.mclk, .resetn, .req_valid,
  .req_write, .req_addr, .req_wdata, .req_ready, .rsp_valid, .rsp_rdata, .rsp_busy, .sram_addr,
  .sram_cs_n, .sram_rw, .sram_oe_n, .sram_data_i, .sram_data_o, .sram_data_oe, .sram_busy_n);

// [tb/dpsc_sram_model.sv]
`timescale 1ns/10ps
// One port of the dual-port memory
module dpsc_sram_model (
  input  wire logic [9:0] sram_addr,
  input  wire logic       sram_cs_n,
  input  wire logic       sram_rw,
  input  wire logic       sram_oe_n,
  input  wire logic [7:0] bus,
  input  wire logic       sram_busy_n,
  output logic [7:0]      dev_q
);
  logic [7:0] mem [1024]; // 1024 byte cells
  logic [7:0] rd_q = 8'h5A;
  logic       drv;
  logic       drv_d;
  logic       drv_dly;
  // Drive only in a selected read with outputs enabled
  assign drv = !sram_cs_n && sram_rw && !sram_oe_n;
  // Slowest access time; busy has no say on a plain read
  assign #(dpsc_pkg::T_ACCESS_NS) drv_dly = drv;
  // Turn-off at once on deselect or R/W low, inside its limit
  assign drv_d = drv && drv_dly;
  // Old data lingers; a released bus shows the inverse of the last value
  always @* if (drv_d) rd_q = mem[sram_addr];
  assign dev_q = drv_d ? rd_q : ~rd_q;
  // Write lands as the overlap ends, refused while busy is low
  always @(posedge sram_rw or posedge sram_cs_n) begin
    if ((sram_cs_n ^ sram_rw) && sram_busy_n) mem[sram_addr] = bus;
  end
endmodule : dpsc_sram_model

// [tb/dual_port_sram_port_access_tb_top.sv]
`timescale 1ns/10ps
module dual_port_sram_port_access_tb_top;
  logic       mclk = 1'b0;
  logic       resetn = 1'b0;
  logic       req_valid = 1'b0;
  logic       req_write = 1'b0;
  logic [9:0] req_addr = 10'h000;
  logic [7:0] req_wdata = 8'h00;
  logic       sram_busy_n = 1'b1;
  logic       req_ready, rsp_valid, rsp_busy, sram_cs_n, sram_rw, sram_oe_n, sram_data_oe, bsy;
  logic [7:0] rsp_rdata, sram_data_o, dev_q, bus, got;
  logic [9:0] sram_addr;
  logic [9:0] ad [4] = '{10'h000, 10'h3FF, 10'h155, 10'h2AA};
  int         fails = 0;
  int         n_tests = 0;
  // Wire level from both drivers
  assign bus = sram_data_oe ? sram_data_o : dev_q;
  always #20 mclk = ~mclk;
  dpsc_host dut (.mclk, .resetn, .req_valid, .req_write, .req_addr, .req_wdata, .req_ready,
    .rsp_valid, .rsp_rdata, .rsp_busy, .sram_addr, .sram_cs_n, .sram_rw, .sram_oe_n,
    .sram_data_i(bus), .sram_data_o, .sram_data_oe, .sram_busy_n);
  dpsc_sram_model u_mem (.sram_addr, .sram_cs_n, .sram_rw, .sram_oe_n, .bus, .sram_busy_n, .dev_q);
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : close_out
  // One request held until taken, then bounded wait for completion
  task automatic xfer(input logic w, input logic [9:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    req_valid <= 1'b1;
    req_write <= w;
    req_addr <= a;
    req_wdata <= d;
    do begin @(posedge mclk); #1; n++; end while (req_ready !== 1'b0 && n < 40);
    @(posedge mclk);
    req_valid <= 1'b0;
    do begin @(posedge mclk); #1; n++; end while (rsp_valid !== 1'b1 && n < 80);
    got = rsp_rdata;
    bsy = rsp_busy;
    if (n >= 80) begin
      fails++;
      close_out();
    end
  endtask : xfer
  task automatic t_idle;
    chk({sram_addr, sram_cs_n, sram_rw, sram_oe_n, sram_data_oe, req_ready, rsp_valid}, 16'h003A);
    $display("test idle done");
  endtask : t_idle
  // Corner and alternating-bit addresses written back to back, then read back
  task automatic t_wr_rd;
    for (int i = 0; i < 4; i++) xfer(1'b1, ad[i], ad[i][7:0] ^ 8'hA5);
    for (int i = 0; i < 4; i++) begin
      xfer(1'b0, ad[i], 8'h00);
      chk({bsy, got}, {8'h00, ad[i][7:0] ^ 8'hA5});
    end
    $display("test write read done");
  endtask : t_wr_rd
  task automatic t_over;
    xfer(1'b1, 10'h3FF, 8'h3C);
    xfer(1'b0, 10'h3FF, 8'h00);
    chk(got, 8'h3C);
    xfer(1'b0, 10'h000, 8'h00);
    chk(got, 8'hA5);
    $display("test overwrite done");
  endtask : t_over
  // Busy low: write refused and flagged, read still correct
  task automatic t_busy;
    @(posedge mclk);
    sram_busy_n <= 1'b0;
    xfer(1'b1, 10'h155, 8'h00);
    chk(bsy, 1'b1);
    xfer(1'b0, 10'h155, 8'h00);
    chk({bsy, got}, 16'h01F0);
    @(posedge mclk);
    sram_busy_n <= 1'b1;
    xfer(1'b0, 10'h2AA, 8'h00);
    chk({bsy, got}, 16'h000F);
    $display("test busy done");
  endtask : t_busy
  initial begin
    repeat (10) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    #1;
    t_idle();
    t_wr_rd();
    t_over();
    t_busy();
    close_out();
  end
endmodule : dual_port_sram_port_access_tb_top
